// [ees_defines.svh]
`ifndef EES_DEFINES_SVH
`define EES_DEFINES_SVH
// control register bit positions and reset value
`define EES_RD_START 0
`define EES_RD_ARM 1
`define EES_WR_START 2
`define EES_WR_ARM 3
`define EES_ER_START 4
`define EES_ER_ARM 5
`define EES_SEL_LO 6
`define EES_CTL_RST 8'h00
// register read selects
`define EES_SEL_LOC 4'h8
`define EES_SEL_CTL 4'h9
// timing
`define EES_CLK_NS 8
`define EES_T2MS_NS 2000000
`define EES_T2MS_CYC ((`EES_T2MS_NS) / (`EES_CLK_NS))
`define EES_RD_CYC 4
`define EES_ARM_WIN 8
`define EES_TW 24
// array shape
`define EES_WORDS 32
`define EES_WW 15
`endif

// [ees_pkg.sv]
`include "ees_defines.svh"
package ees_pkg;
  typedef enum logic [1:0] {EES_IDLE, EES_ERASE, EES_WRITE, EES_READ} ees_op_t;
  typedef struct packed {
    logic [7:0] ctl;
    logic [4:0] loc;
    logic [7:0][7:0] dat;
    ees_op_t op;
    logic [`EES_TW-1:0] timer;
    logic win_er;
    logic win_wr;
    logic [3:0] win_cnt;
    logic fail;
    logic stall;
    logic [7:0] rd;
  } ees_st_t;
  typedef struct packed {
    logic [`EES_WORDS-1:0][`EES_WW-1:0] mem;
  } ees_arr_t;
endpackage

// [ees_array.sv]
`timescale 1ns/1ps
`include "ees_defines.svh"
module ees_array import ees_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [4:0] addr_in,
  input wire logic wr_in,
  input wire logic er_in,
  input wire logic [3:0][`EES_WW-1:0] wdata_in,
  output logic [`EES_WW-1:0] word_out
);
  ees_arr_t s;
  ees_arr_t nxt;

  always_comb begin
    nxt = s;
    for (int i = 0; i < `EES_WORDS; i++) begin
      if (er_in && addr_in[4] == i[4]) begin
        nxt.mem[i] = '0;
      end else if (wr_in && addr_in[4:2] == i[4:2]) begin
        nxt.mem[i] = wdata_in[i[1:0]];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s <= '0;
    end else begin
      s <= nxt;
    end
  end

  assign word_out = s.mem[addr_in];

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  property p_page_zero;
    er_in |=> s.mem[{$past(addr_in[4]), 4'h0}] == '0 && s.mem[{$past(addr_in[4]), 4'hf}] == '0;
  endproperty
  a_page_zero: assert property (p_page_zero) else $error("erased page not zero");

  property p_unit_write;
    wr_in |=> s.mem[{$past(addr_in[4:2]), 2'b11}] == $past(wdata_in[3])
      && s.mem[{$past(addr_in[4:2]), 2'b00}] == $past(wdata_in[0]);
  endproperty
  a_unit_write: assert property (p_unit_write) else $error("write unit wrong");
endmodule

// [ees_sequencer.sv]
`timescale 1ns/1ps
`include "ees_defines.svh"
// Contract
// - write or erase start counts only on the write right after arming.
// - entering idle or sleep mid-cycle makes the cycle fail.
// - top two control bits pick 2, 4, 8 or 16 ms.
// - erase start bit clears when the erase ends; software polls it.
// - write start bit clears when the write ends; software polls it.
// - read start bit clears when the read ends before data use.
// - address never auto-increments; every read reloads it and restarts.
// - a finished read puts the word in data pair zero.
// - writing zero to control clears read arm, stopping further reads.
// - read arms then starts, without interrupt masking.
// - write stores four words; address bits 4 to 2 select the unit.
// - erase zeroes sixteen words; address bit 4 selects the page.
// - processor stalls from activation until the cycle ends.
// - erase arm and write arm clear when their cycles end without a halt; a halt leaves them set.
module ees_sequencer import ees_pkg::*; #(
  parameter int T2MS_CYC = `EES_T2MS_CYC,
  parameter int RD_CYC = `EES_RD_CYC,
  parameter int ARM_WIN = `EES_ARM_WIN
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic halt_in,
  input wire logic loc_wr_in,
  input wire logic [4:0] loc_in,
  input wire logic dat_wr_in,
  input wire logic [2:0] dat_sel_in,
  input wire logic [7:0] dat_in,
  input wire logic ctl_wr_in,
  input wire logic [7:0] ctl_in,
  input wire logic [3:0] rd_sel_in,
  output logic [7:0] rd_data_out,
  output logic [7:0] ctl_out,
  output logic stall_out,
  output logic fail_out
);
  ees_st_t s;
  ees_st_t nxt;
  logic acc_er;
  logic acc_wr;
  logic acc_rd;
  logic arr_wr;
  logic arr_er;
  logic [`EES_TW-1:0] load;
  logic [`EES_WW-1:0] word;
  logic [3:0][`EES_WW-1:0] wdata;

  always_comb begin
    for (int k = 0; k < 4; k++) begin
      wdata[k] = {s.dat[2*k+1][6:0], s.dat[2*k]};
    end
  end

  always_comb begin
    nxt = s;
    acc_er = 1'b0;
    acc_wr = 1'b0;
    acc_rd = 1'b0;
    arr_wr = 1'b0;
    arr_er = 1'b0;
    load = '0;
    if (s.win_cnt != 4'h0) begin
      nxt.win_cnt = 4'(s.win_cnt - 4'h1);
    end else begin
      nxt.win_er = 1'b0;
      nxt.win_wr = 1'b0;
    end
    if (s.op != EES_IDLE) begin
      if (halt_in) begin
        nxt.op = EES_IDLE;
        nxt.fail = 1'b1;
        nxt.ctl[`EES_ER_START] = 1'b0;
        nxt.ctl[`EES_WR_START] = 1'b0;
        nxt.ctl[`EES_RD_START] = 1'b0;
      end else if (s.timer == '0) begin
        nxt.op = EES_IDLE;
        unique case (s.op)
          EES_ERASE: begin
            arr_er = 1'b1;
            nxt.ctl[`EES_ER_START] = 1'b0;
            nxt.ctl[`EES_ER_ARM] = 1'b0;
          end
          EES_WRITE: begin
            arr_wr = 1'b1;
            nxt.ctl[`EES_WR_START] = 1'b0;
            nxt.ctl[`EES_WR_ARM] = 1'b0;
          end
          EES_READ: begin
            nxt.ctl[`EES_RD_START] = 1'b0;
            nxt.dat[0] = word[7:0];
            nxt.dat[1] = {1'b0, word[14:8]};
          end
          EES_IDLE: begin
          end
        endcase
      end else begin
        nxt.timer = s.timer - 1'b1;
      end
    end else begin
      if (loc_wr_in) begin
        nxt.loc = loc_in;
        nxt.win_cnt = 4'h0;
        nxt.win_er = 1'b0;
        nxt.win_wr = 1'b0;
      end
      if (dat_wr_in) begin
        nxt.dat[dat_sel_in] = dat_sel_in[0] ? {1'b0, dat_in[6:0]} : dat_in;
        nxt.win_cnt = 4'h0;
        nxt.win_er = 1'b0;
        nxt.win_wr = 1'b0;
      end
      if (ctl_wr_in) begin
        acc_er = ctl_in[`EES_ER_START] && ctl_in[`EES_ER_ARM] && s.ctl[`EES_ER_ARM]
          && s.win_er && !halt_in;
        acc_wr = !acc_er && ctl_in[`EES_WR_START] && ctl_in[`EES_WR_ARM]
          && s.ctl[`EES_WR_ARM] && s.win_wr && !halt_in;
        acc_rd = !acc_er && !acc_wr && ctl_in[`EES_RD_START] && ctl_in[`EES_RD_ARM]
          && s.ctl[`EES_RD_ARM] && !halt_in;
        nxt.ctl = ctl_in;
        nxt.ctl[`EES_ER_START] = acc_er;
        nxt.ctl[`EES_WR_START] = acc_wr;
        nxt.ctl[`EES_RD_START] = acc_rd;
        nxt.win_er = ctl_in[`EES_ER_ARM] && !s.ctl[`EES_ER_ARM];
        nxt.win_wr = ctl_in[`EES_WR_ARM] && !s.ctl[`EES_WR_ARM];
        nxt.win_cnt = (nxt.win_er || nxt.win_wr) ? 4'(ARM_WIN) : 4'h0;
        if (acc_rd) begin
          load = `EES_TW'(RD_CYC);
        end else begin
          load = `EES_TW'(T2MS_CYC) << ctl_in[`EES_SEL_LO +: 2];
        end
        if (acc_er || acc_wr || acc_rd) begin
          nxt.op = acc_er ? EES_ERASE : (acc_wr ? EES_WRITE : EES_READ);
          nxt.timer = load - 1'b1;
          nxt.fail = 1'b0;
        end
      end
    end
    nxt.stall = (nxt.op != EES_IDLE);
    if (rd_sel_in == `EES_SEL_LOC) begin
      nxt.rd = {3'h0, s.loc};
    end else if (rd_sel_in == `EES_SEL_CTL) begin
      nxt.rd = s.ctl;
    end else if (rd_sel_in[3]) begin
      nxt.rd = 8'h00;
    end else begin
      nxt.rd = s.dat[rd_sel_in[2:0]];
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s <= '0;
    end else begin
      s <= nxt;
    end
  end

  ees_array u_arr (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .addr_in(s.loc),
    .wr_in(arr_wr),
    .er_in(arr_er),
    .wdata_in(wdata),
    .word_out(word)
  );

  assign rd_data_out = s.rd;
  assign ctl_out = s.ctl;
  assign stall_out = s.stall;
  assign fail_out = s.fail;

  // assertion helpers
  logic [`EES_TW-1:0] len;
  logic done_ok;
  always_ff @(posedge clk_in) begin
    if (rst_in || s.op == EES_IDLE) begin
      len <= `EES_TW'(1);
    end else begin
      len <= len + 1'b1;
    end
  end
  assign done_ok = s.op != EES_IDLE && s.timer == '0 && !halt_in;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  property p_lone_start;
    !stall_out && ctl_wr_in && ctl_in[`EES_WR_START] && !(s.win_wr && s.ctl[`EES_WR_ARM])
      |=> !ctl_out[`EES_WR_START] && !(s.op == EES_WRITE);
  endproperty
  a_lone_start: assert property (p_lone_start) else $error("stray start taken");

  property p_arm_start;
    !stall_out && ctl_wr_in && ctl_in[`EES_WR_START] && ctl_in[`EES_WR_ARM]
      && !ctl_in[`EES_ER_START] && s.win_wr && s.ctl[`EES_WR_ARM] && !halt_in
      |=> stall_out && ctl_out[`EES_WR_START];
  endproperty
  a_arm_start: assert property (p_arm_start) else $error("write not activated");

  property p_duration;
    done_ok && s.op != EES_READ |-> len == (`EES_TW'(T2MS_CYC) << s.ctl[`EES_SEL_LO +: 2]);
  endproperty
  a_duration: assert property (p_duration) else $error("cycle length wrong");

  property p_erase_done;
    done_ok && s.op == EES_ERASE
      |=> !ctl_out[`EES_ER_START] && !ctl_out[`EES_ER_ARM] && !stall_out;
  endproperty
  a_erase_done: assert property (p_erase_done) else $error("erase end bits");

  property p_write_done;
    done_ok && s.op == EES_WRITE
      |=> !ctl_out[`EES_WR_START] && !ctl_out[`EES_WR_ARM] && !stall_out;
  endproperty
  a_write_done: assert property (p_write_done) else $error("write end bits");

  property p_read_done;
    done_ok && s.op == EES_READ
      |=> !ctl_out[`EES_RD_START] && s.dat[0] == $past(word[7:0]) && s.loc == $past(s.loc);
  endproperty
  a_read_done: assert property (p_read_done) else $error("read result wrong");

  property p_clear_read;
    !stall_out && ctl_wr_in && ctl_in == 8'h00 |=> !ctl_out[`EES_RD_ARM] ##1 !stall_out;
  endproperty
  a_clear_read: assert property (p_clear_read) else $error("read arm kept");

  property p_halt_fail;
    stall_out && halt_in |=> !stall_out && fail_out && !ctl_out[`EES_ER_START]
      && !ctl_out[`EES_WR_START] && !ctl_out[`EES_RD_START];
  endproperty
  a_halt_fail: assert property (p_halt_fail) else $error("halted cycle survived");

  property p_read_noarm;
    !stall_out && ctl_wr_in && ctl_in[`EES_RD_START] && !s.ctl[`EES_RD_ARM]
      && !ctl_in[`EES_ER_START] && !ctl_in[`EES_WR_START] |=> !stall_out;
  endproperty
  a_read_noarm: assert property (p_read_noarm) else $error("read without arm");

  property p_stall_hold;
    stall_out && s.timer != '0 && !halt_in |=> stall_out;
  endproperty
  a_stall_hold: assert property (p_stall_hold) else $error("stall dropped");

  c_erase: cover property (done_ok && s.op == EES_ERASE);
  c_write: cover property (done_ok && s.op == EES_WRITE);
  c_read: cover property (done_ok && s.op == EES_READ);
  c_fail: cover property (stall_out && halt_in);
endmodule

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  logic clk_in = 0;
  logic rst_in = 1;
  logic halt_in = 0;
  logic loc_wr_in = 0;
  logic dat_wr_in = 0;
  logic ctl_wr_in = 0;
  logic [4:0] loc_in = 0;
  logic [2:0] dat_sel_in = 0;
  logic [7:0] dat_in = 0;
  logic [7:0] ctl_in = 0;
  logic [3:0] rd_sel_in = 0;
  logic [7:0] rd_data_out;
  logic [7:0] ctl_out;
  logic stall_out;
  logic fail_out;
  logic [14:0] mem [32];
  logic [9:0] exp_q [$];
  logic [9:0] e;
  logic [31:0] seed = 32'hbc5e;
  int fail_count = 0;
  int n_checks = 0;
  always #4 clk_in = ~clk_in;
  ees_sequencer #(.T2MS_CYC(8)) dut (.clk_in(clk_in), .rst_in(rst_in), .halt_in(halt_in),
    .loc_wr_in(loc_wr_in), .loc_in(loc_in), .dat_wr_in(dat_wr_in), .dat_sel_in(dat_sel_in),
    .dat_in(dat_in), .ctl_wr_in(ctl_wr_in), .ctl_in(ctl_in), .rd_sel_in(rd_sel_in),
    .rd_data_out(rd_data_out), .ctl_out(ctl_out), .stall_out(stall_out), .fail_out(fail_out));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] want, input string msg);
    n_checks++;
    if (got !== want) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, msg, got, want);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // compare the oldest note with the outputs after the edge
  always @(posedge clk_in) begin
    if (exp_q.size() > 0) begin
      #1;
      e = exp_q.pop_front();
      case (e[9:8])
        2'd0: chk(rd_data_out, e[7:0], "register read");
        2'd1: chk({7'h00, stall_out}, e[7:0], "stall");
        2'd2: chk({7'h00, fail_out}, e[7:0], "fail flag");
        default: chk(ctl_out, e[7:0], "control out");
      endcase
    end
  end
  task automatic note(input logic [1:0] k, input logic [3:0] sel, input logic [7:0] v);
    @(negedge clk_in);
    loc_wr_in = 0;
    dat_wr_in = 0;
    ctl_wr_in = 0;
    rd_sel_in = sel;
    exp_q.push_back({k, v});
    @(negedge clk_in);
  endtask
  task automatic put(input int kind, input logic [7:0] v, input logic [2:0] sel);
    @(negedge clk_in);
    loc_wr_in = (kind == 0);
    dat_wr_in = (kind == 1);
    ctl_wr_in = (kind == 2);
    loc_in = v[4:0];
    dat_sel_in = sel;
    dat_in = v;
    ctl_in = v;
  endtask
  task automatic go(input logic [7:0] arm, input logic [7:0] start, output int n);
    put(2, arm, 0);
    put(2, start, 0);
    @(negedge clk_in);
    ctl_wr_in = 0;
    n = 0;
    while (stall_out === 1'b1 && n < 200) begin
      n++;
      @(negedge clk_in);
    end
  endtask
  task automatic rdw(input logic [4:0] a, input logic [14:0] w);
    int n;
    put(0, {3'h0, a}, 0);
    go(8'h02, 8'h03, n);
    chk(n[7:0], 8'h04, "read length");
    note(0, 4'h9, 8'h02);
    note(0, 4'h0, w[7:0]);
    note(0, 4'h1, {1'b0, w[14:8]});
  endtask
  task automatic wru(input logic [2:0] u, input logic [1:0] ts);
    logic [14:0] w;
    int n;
    put(0, {3'h0, u, 2'b11}, 0);
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      w = seed[14:0];
      put(1, w[7:0], 3'(2 * k));
      put(1, {1'b0, w[14:8]}, 3'(2 * k + 1));
      mem[{u, 2'(k)}] = w;
    end
    go({ts, 6'h08}, {ts, 6'h0c}, n);
    chk(n[7:0], 8'(8 << ts), "write length");
    note(0, 4'h9, {ts, 6'h00});
    note(3, 4'h9, {ts, 6'h00});
  endtask
  initial begin
    int n;
    repeat (16) @(negedge clk_in);
    rst_in = 0;
    note(0, 4'h9, 8'h00);
    note(0, 4'h8, 8'h00);
    note(1, 4'h0, 8'h00);
    note(2, 4'h0, 8'h00);
    $display("test reset done");
    for (int t = 0; t < 4; t++) wru(3'(t), 2'(t));
    wru(3'h5, 2'h0);
    for (int a = 0; a < 24; a += 5) rdw(5'(a), mem[a]);
    $display("test write and read done");
    put(2, 8'h08, 0);
    put(0, 8'h00, 0);
    put(2, 8'h0c, 0);
    note(1, 4'h9, 8'h00);
    note(0, 4'h9, 8'h08);
    note(3, 4'h9, 8'h08);
    put(2, 8'h00, 0);
    $display("test stray start done");
    put(0, 8'h1f, 0);
    go(8'h20, 8'h30, n);
    chk(n[7:0], 8'h08, "erase length");
    note(0, 4'h9, 8'h00);
    note(0, 4'h8, 8'h1f);
    note(0, 4'hc, 8'h00);
    for (int a = 16; a < 32; a++) mem[a] = 0;
    rdw(5'h15, mem[21]);
    rdw(5'h0e, mem[14]);
    $display("test erase done");
    put(2, 8'h00, 0);
    put(2, 8'h01, 0);
    note(1, 4'h9, 8'h00);
    note(0, 4'h9, 8'h00);
    $display("test read disable done");
    put(0, 8'h08, 0);
    put(2, 8'h08, 0);
    put(2, 8'h0c, 0);
    @(negedge clk_in);
    ctl_wr_in = 0;
    repeat (2) @(negedge clk_in);
    halt_in = 1;
    @(negedge clk_in);
    halt_in = 0;
    note(2, 4'h9, 8'h01);
    note(1, 4'h9, 8'h00);
    note(0, 4'h9, 8'h08);
    note(3, 4'h9, 8'h08);
    rdw(5'h08, mem[8]);
    note(2, 4'h9, 8'h00);
    $display("test halt abort done");
    summarize();
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    fail_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    summarize();
  end
endmodule
